// ### logic/scu_pkg.sv
// shared constants for the bus snooping crc unit and its bus fabric partner
// assumes one clock domain, synchronous active-high reset
package scu_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    // mirrored alias window: an address is in a bus's window when addr & MIRROR_MASK equals its base
    localparam logic [31:0] MIRROR_MASK = 32'hf000_0000;
    localparam logic [31:0] CODE_MIRROR_BASE = 32'h1000_0000;
    localparam logic [31:0] SYS_MIRROR_BASE = 32'h3000_0000;
    localparam logic [31:0] MIRROR_CLR = 32'h0fff_ffff;
    // polynomials, result reset value and capture fifo size
    localparam logic [7:0] POLY8 = 8'h07;
    localparam logic [15:0] POLY16_FIRST = 16'h8005;
    localparam logic [15:0] POLY16_SECOND = 16'h1021;
    localparam logic [31:0] POLY32 = 32'h04c1_1db7;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_W = 8;

    typedef enum logic [1:0] {
        SCU_POLY_8 = 2'h0,
        SCU_POLY_16_FIRST = 2'h1,
        SCU_POLY_16_SECOND = 2'h3,
        SCU_POLY_32 = 2'h2
    } scu_poly_type;

    typedef enum logic [1:0] {
        SCU_SIZE_BYTE = 2'h0,
        SCU_SIZE_HALF = 2'h1,
        SCU_SIZE_WORD = 2'h2
    } scu_size_type;

    typedef enum logic [1:0] {
        SCU_ZONE_NONE = 2'h0,
        SCU_ZONE_OWN = 2'h1,
        SCU_ZONE_OTHER = 2'h2
    } scu_zone_type;
endpackage

// ### logic/scu_bus_if.sv
// snoop carrier: one beat per bus, read or write, from the fabric to the crc unit
// assumes fabric and crc unit share clk and sys_rst
interface scu_bus_if;
    import scu_pkg::*;
    // code data bus
    logic cd_valid;
    logic cd_write;
    logic cd_fetch;
    logic cd_debug;
    logic cd_blocked;
    logic [31:0] cd_addr;
    logic [31:0] cd_data;
    scu_size_type cd_size;
    // system bus
    logic sb_valid;
    logic sb_write;
    logic sb_fetch;
    logic sb_debug;
    logic sb_blocked;
    logic [31:0] sb_addr;
    logic [31:0] sb_data;
    scu_size_type sb_size;
    // back-pressure from the crc unit's capture fifo and its holding slot
    logic snoop_ready;

    modport fabric (
        output cd_valid, cd_write, cd_fetch, cd_debug, cd_blocked, cd_addr, cd_data, cd_size,
        output sb_valid, sb_write, sb_fetch, sb_debug, sb_blocked, sb_addr, sb_data, sb_size,
        input snoop_ready
    );
    modport crc (
        input cd_valid, cd_write, cd_fetch, cd_debug, cd_blocked, cd_addr, cd_data, cd_size,
        input sb_valid, sb_write, sb_fetch, sb_debug, sb_blocked, sb_addr, sb_data, sb_size,
        output snoop_ready
    );
endinterface

// ### logic/scu_fifo.sv
// byte fifo with valid/ready on both sides, flip-flop storage
// assumes single clock, synchronous active-high reset
module scu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule

// ### logic/scu_crc.sv
// crc unit end: snoops both buses, buffers qualifying bytes, folds them into the result
// assumes the fabric presents one read beat per bus per cycle with data valid
// assumes software clears and selects the polynomial before it feeds bytes
module scu_crc
    import scu_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // snooped buses
    scu_bus_if.crc bus,
    // software control
    input wire logic clear_strobe,
    input wire logic config_write,
    input wire scu_poly_type config_poly,
    input wire logic result_write,
    input wire logic [31:0] result_wdata,
    // software status
    output logic [31:0] crc_result_reg,
    output scu_poly_type crc_config_reg,
    output logic busy_reg
);
    // a beat counts only as a processor data read of one byte inside the bus's alias window
    function automatic logic qualifies(input logic valid, input logic wr, input logic fetch,
                                       input logic dbg, input logic blk,
                                       input logic [31:0] addr, input scu_size_type size,
                                       input logic [31:0] base);
        qualifies = valid && !wr && !fetch && !dbg && !blk
            && ((addr & MIRROR_MASK) == base)
            && (size == SCU_SIZE_BYTE);
    endfunction

    // one step of msb-first crc over a byte, width given by the selected polynomial
    function automatic logic [31:0] fold(input logic [31:0] crc, input logic [7:0] data,
                                         input scu_poly_type sel);
        logic [31:0] c;
        logic [31:0] poly;
        int top;
        c = crc;
        poly = POLY32;
        top = 31;
        unique case (sel)
            SCU_POLY_8: begin
                poly = {24'h00_0000, POLY8};
                top = 7;
            end
            SCU_POLY_16_FIRST: begin
                poly = {16'h0000, POLY16_FIRST};
                top = 15;
            end
            SCU_POLY_16_SECOND: begin
                poly = {16'h0000, POLY16_SECOND};
                top = 15;
            end
            SCU_POLY_32: begin
                poly = POLY32;
                top = 31;
            end
        endcase
        // bits above a narrow crc collect junk here; they never reach the top bit in use
        for (int i = 7; i >= 0; i--) begin
            if (c[top] ^ data[i]) begin
                c = (c << 1) ^ poly;
            end else begin
                c = c << 1;
            end
        end
        // narrow results keep only their own width, upper bits read as zero
        unique case (sel)
            SCU_POLY_8: fold = {24'h00_0000, c[7:0]};
            SCU_POLY_16_FIRST, SCU_POLY_16_SECOND: fold = {16'h0000, c[15:0]};
            default: fold = c;
        endcase
    endfunction

    logic cd_hit;
    logic sb_hit;
    logic pend_reg;
    logic [7:0] pend_data_reg;
    logic in_valid;
    logic in_ready;
    logic [7:0] in_data;
    logic out_valid;
    logic [7:0] out_data;

    // lane 0 is the code data bus and lane 1 the system bus; lane 0 wins a shared cycle
    localparam int LANES = 2;

    logic [LANES-1:0] lane_valid;
    logic [LANES-1:0] lane_write;
    logic [LANES-1:0] lane_fetch;
    logic [LANES-1:0] lane_debug;
    logic [LANES-1:0] lane_blocked;
    logic [LANES-1:0] lane_hit;
    logic [31:0] lane_addr [LANES];
    logic [31:0] lane_base [LANES];
    logic [7:0] lane_byte [LANES];
    scu_size_type lane_size [LANES];

    assign lane_valid = {bus.sb_valid, bus.cd_valid};
    assign lane_write = {bus.sb_write, bus.cd_write};
    assign lane_fetch = {bus.sb_fetch, bus.cd_fetch};
    assign lane_debug = {bus.sb_debug, bus.cd_debug};
    assign lane_blocked = {bus.sb_blocked, bus.cd_blocked};
    assign lane_addr[0] = bus.cd_addr;
    assign lane_addr[1] = bus.sb_addr;
    assign lane_base[0] = CODE_MIRROR_BASE;
    assign lane_base[1] = SYS_MIRROR_BASE;
    assign lane_byte[0] = bus.cd_data[7:0];
    assign lane_byte[1] = bus.sb_data[7:0];
    assign lane_size[0] = bus.cd_size;
    assign lane_size[1] = bus.sb_size;

    // one qualifier per bus, identical apart from the alias base, so the two cannot drift
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign lane_hit[g] = qualifies(lane_valid[g], lane_write[g], lane_fetch[g],
                                       lane_debug[g], lane_blocked[g], lane_addr[g],
                                       lane_size[g], lane_base[g]);
    end

    assign cd_hit = lane_hit[0];
    assign sb_hit = lane_hit[1];

    // both buses may hit in one cycle; the system-bus byte waits in a holding slot until the fifo next has room
    assign in_valid = pend_reg || cd_hit || sb_hit;
    assign in_data = pend_reg ? pend_data_reg : (cd_hit ? lane_byte[0] : lane_byte[1]);
    assign bus.snoop_ready = in_ready && !pend_reg;

    // the held byte takes the next free slot ahead of any new beat, keeping bus order
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_reg <= 1'b0;
            pend_data_reg <= 8'h00;
        end else if (pend_reg) begin
            pend_reg <= !in_ready;
        end else if (cd_hit && sb_hit && in_ready) begin
            pend_reg <= 1'b1;
            pend_data_reg <= lane_byte[1];
        end
    end

    // the fifo absorbs bursts while software holds clear or restore; once full it
    // back-pressures both buses rather than dropping a byte
    scu_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_data),
        .out_valid(out_valid),
        .out_ready(!clear_strobe && !result_write),
        .out_data(out_data)
    );

    // a polynomial change applies to bytes still queued, so switch only when idle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            crc_config_reg <= SCU_POLY_8;
        end else if (config_write) begin
            crc_config_reg <= config_poly;
        end
    end

    // clear and restore stall the drain so that no byte is folded over them
    // a restore is taken as written, upper bits included, whatever the width
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            crc_result_reg <= RESULT_RESET;
        end else if (clear_strobe) begin
            crc_result_reg <= RESULT_RESET;
        end else if (result_write) begin
            crc_result_reg <= result_wdata;
        end else if (out_valid) begin
            crc_result_reg <= fold(crc_result_reg, out_data, crc_config_reg);
        end
    end

    // busy tells software that queued bytes are not folded yet; the result is final
    // only once busy has been low with no read in flight
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= out_valid || in_valid;
        end
    end
endmodule

// ### logic/scu_fabric.sv
// fabric end: turns core read/write requests into snoop beats on both buses
// assumes the core issues at most one request per bus per cycle
module scu_fabric
    import scu_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // snoop carrier
    scu_bus_if.fabric bus,
    // core request on the code data bus
    input wire logic cd_req,
    input wire logic cd_req_write,
    input wire logic cd_req_fetch,
    input wire logic cd_req_debug,
    input wire logic [31:0] cd_req_addr,
    input wire logic [31:0] cd_req_data,
    input wire scu_size_type cd_req_size,
    input wire scu_zone_type cd_req_zone,
    // core request on the system bus
    input wire logic sb_req,
    input wire logic sb_req_write,
    input wire logic sb_req_debug,
    input wire logic [31:0] sb_req_addr,
    input wire logic [31:0] sb_req_data,
    input wire scu_size_type sb_req_size,
    input wire scu_zone_type sb_req_zone,
    // execute-only target of the code data request
    input wire logic cd_req_exec_only,
    // answers to the core
    output logic req_ready_reg,
    output logic [31:0] cd_rdata_reg
);
    // other-zone accesses are blocked and read as zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus.cd_valid <= 1'b0;
            bus.cd_write <= 1'b0;
            bus.cd_fetch <= 1'b0;
            bus.cd_debug <= 1'b0;
            bus.cd_blocked <= 1'b0;
            bus.cd_addr <= 32'h0000_0000;
            bus.cd_data <= 32'h0000_0000;
            bus.cd_size <= SCU_SIZE_BYTE;
            cd_rdata_reg <= 32'h0000_0000;
        end else if (bus.snoop_ready) begin
            bus.cd_valid <= cd_req;
            bus.cd_write <= cd_req_write;
            bus.cd_fetch <= cd_req_fetch;
            bus.cd_debug <= cd_req_debug;
            bus.cd_blocked <= (cd_req_zone == SCU_ZONE_OTHER);
            bus.cd_addr <= cd_req_addr;
            bus.cd_data <= (cd_req_zone == SCU_ZONE_OTHER) ? 32'h0000_0000 : cd_req_data;
            bus.cd_size <= cd_req_size;
            cd_rdata_reg <= (cd_req_exec_only || cd_req_zone == SCU_ZONE_OTHER)
                ? 32'h0000_0000 : cd_req_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus.sb_valid <= 1'b0;
            bus.sb_write <= 1'b0;
            bus.sb_fetch <= 1'b0;
            bus.sb_debug <= 1'b0;
            bus.sb_blocked <= 1'b0;
            bus.sb_addr <= 32'h0000_0000;
            bus.sb_data <= 32'h0000_0000;
            bus.sb_size <= SCU_SIZE_BYTE;
        end else if (bus.snoop_ready) begin
            bus.sb_valid <= sb_req;
            bus.sb_write <= sb_req_write;
            bus.sb_fetch <= 1'b0;
            bus.sb_debug <= sb_req_debug;
            bus.sb_blocked <= (sb_req_zone == SCU_ZONE_OTHER);
            bus.sb_addr <= sb_req_addr;
            bus.sb_data <= (sb_req_zone == SCU_ZONE_OTHER) ? 32'h0000_0000 : sb_req_data;
            bus.sb_size <= sb_req_size;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_ready_reg <= 1'b0;
        end else begin
            req_ready_reg <= bus.snoop_ready;
        end
    end
endmodule

// ### verif/scu_monitor.sv
// assertions on the snoop carrier and the crc unit's control and result
// assumes one clock domain, sys_rst synchronous active high
module scu_monitor
    import scu_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // carrier
    input wire logic cd_valid,
    input wire logic sb_valid,
    input wire logic sb_fetch,
    input wire logic [31:0] cd_addr,
    input wire logic [31:0] cd_data,
    input wire logic snoop_ready,
    // crc unit control and status
    input wire logic clear_strobe,
    input wire logic result_write,
    input wire logic [31:0] result_wdata,
    input wire logic [31:0] crc_result_reg,
    input wire logic busy_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_stall;
        cd_valid && !snoop_ready;
    endsequence
    sequence s_quiet;
        !busy_reg && !cd_valid && !sb_valid && !clear_strobe && !result_write;
    endsequence
    a_ready_after_reset: assert property ($fell(sys_rst) |=> snoop_ready)
        else $error("snoop_ready low after reset");
    a_idle_after_reset: assert property ($past(sys_rst) |-> !cd_valid && !sb_valid)
        else $error("beat offered straight out of reset");
    a_beat_held: assert property (s_stall |=> cd_valid && $stable(cd_addr) && $stable(cd_data))
        else $error("stalled beat changed or dropped");
    // drains within the fifo depth plus the restore stall the bench uses
    a_ready_recovers: assert property (!snoop_ready |-> ##[1:64] snoop_ready)
        else $error("snoop_ready stuck low");
    a_result_stands: assert property (s_quiet |=> $stable(crc_result_reg))
        else $error("result moved without a captured byte");
    a_clear_zeroes: assert property (clear_strobe |=> crc_result_reg == RESULT_RESET)
        else $error("clear did not reset result");
    a_restore_value: assert property (result_write && !clear_strobe |=>
        crc_result_reg == $past(result_wdata))
        else $error("restore write not taken");
    a_sysbus_no_fetch: assert property (sb_valid |-> !sb_fetch)
        else $error("fetch beat on system bus");
endmodule

// ### verif/tb_top.sv
// self-checking bench: fabric and crc unit joined by the snoop carrier
// assumes a 40 ns clock and a capture fifo shortened to 4 entries
module tb_top
    import scu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // fl: write, fetch, debug, other zone, execute-only
    typedef struct {
        scu_poly_type poly;
        logic sb;
        scu_size_type size;
        logic [31:0] addr;
        logic [7:0] dat;
        logic [4:0] fl;
        logic fold;
    } scu_row_type;
    scu_row_type rows [13] = '{
        '{SCU_POLY_8, 1'h0, SCU_SIZE_BYTE, 32'h1000_0010, 8'ha5, 5'h00, 1'h1},
        '{SCU_POLY_16_FIRST, 1'h0, SCU_SIZE_BYTE, 32'h1000_0011, 8'h3c, 5'h00, 1'h1},
        '{SCU_POLY_16_SECOND, 1'h0, SCU_SIZE_BYTE, 32'h1000_0012, 8'h81, 5'h00, 1'h1},
        '{SCU_POLY_32, 1'h0, SCU_SIZE_BYTE, 32'h1000_0013, 8'h5a, 5'h00, 1'h1},
        '{SCU_POLY_16_FIRST, 1'h1, SCU_SIZE_BYTE, 32'h1000_0044, 8'h77, 5'h00, 1'h1},
        '{SCU_POLY_32, 1'h0, SCU_SIZE_HALF, 32'h1000_0020, 8'h11, 5'h00, 1'h0},
        '{SCU_POLY_32, 1'h1, SCU_SIZE_WORD, 32'h1000_0024, 8'h22, 5'h00, 1'h0},
        '{SCU_POLY_16_SECOND, 1'h0, SCU_SIZE_BYTE, 32'h0000_0030, 8'h33, 5'h00, 1'h0},
        '{SCU_POLY_8, 1'h0, SCU_SIZE_BYTE, 32'h1000_0030, 8'h44, 5'h10, 1'h0},
        '{SCU_POLY_8, 1'h0, SCU_SIZE_BYTE, 32'h1000_0034, 8'h55, 5'h08, 1'h0},
        '{SCU_POLY_8, 1'h0, SCU_SIZE_BYTE, 32'h1000_0038, 8'h66, 5'h04, 1'h0},
        '{SCU_POLY_8, 1'h0, SCU_SIZE_BYTE, 32'h1000_003c, 8'h99, 5'h02, 1'h0},
        '{SCU_POLY_8, 1'h0, SCU_SIZE_BYTE, 32'h1000_0040, 8'hc3, 5'h01, 1'h1}};
    logic clk, sys_rst, cd_go, sb_go, clear_strobe, config_write, result_write, busy_reg;
    logic req_ready_reg;
    logic [31:0] result_wdata, crc_result_reg, cd_rdata_reg, e;
    scu_poly_type config_poly, crc_config_reg;
    scu_row_type cur;
    int error_cnt, check_count;
    scu_bus_if bus_if ();
    scu_crc #(.DEPTH(4)) u_scu_crc (.clk(clk), .sys_rst(sys_rst), .bus(bus_if),
        .clear_strobe(clear_strobe), .config_write(config_write), .config_poly(config_poly),
        .result_write(result_write), .result_wdata(result_wdata),
        .crc_result_reg(crc_result_reg), .crc_config_reg(crc_config_reg), .busy_reg(busy_reg));
    // system bus sees the same row moved into its own alias, with the byte inverted
    scu_fabric u_scu_fabric (.clk(clk), .sys_rst(sys_rst), .bus(bus_if),
        .cd_req(cd_go), .cd_req_write(cur.fl[4]), .cd_req_fetch(cur.fl[3]),
        .cd_req_debug(cur.fl[2]), .cd_req_addr(cur.addr), .cd_req_data({24'h5a5a5a, cur.dat}),
        .cd_req_size(cur.size), .cd_req_zone(cur.fl[1] ? SCU_ZONE_OTHER : SCU_ZONE_OWN),
        .sb_req(sb_go), .sb_req_write(cur.fl[4]), .sb_req_debug(cur.fl[2]),
        .sb_req_addr(cur.addr | 32'h2000_0000), .sb_req_data({24'h5a5a5a, ~cur.dat}),
        .sb_req_size(cur.size), .sb_req_zone(cur.fl[1] ? SCU_ZONE_OTHER : SCU_ZONE_OWN),
        .cd_req_exec_only(cur.fl[0]), .req_ready_reg(req_ready_reg),
        .cd_rdata_reg(cd_rdata_reg));
    scu_monitor u_scu_monitor (.clk(clk), .sys_rst(sys_rst), .cd_valid(bus_if.cd_valid),
        .sb_valid(bus_if.sb_valid), .sb_fetch(bus_if.sb_fetch), .cd_addr(bus_if.cd_addr),
        .cd_data(bus_if.cd_data), .snoop_ready(bus_if.snoop_ready),
        .clear_strobe(clear_strobe), .result_write(result_write), .result_wdata(result_wdata),
        .crc_result_reg(crc_result_reg), .busy_reg(busy_reg));

    function automatic logic [31:0] crc(input logic [31:0] r, input logic [7:0] b,
        input scu_poly_type p);
        int w;
        logic [31:0] a, g;
        w = p == SCU_POLY_8 ? 8 : p == SCU_POLY_32 ? 32 : 16;
        g = p == SCU_POLY_8 ? {POLY8, 24'h0} : p == SCU_POLY_16_FIRST ? {POLY16_FIRST, 16'h0}
            : p == SCU_POLY_16_SECOND ? {POLY16_SECOND, 16'h0} : POLY32;
        a = (r << (32 - w)) ^ {b, 24'h0};
        for (int i = 0; i < 8; i++) a = a[31] ? (a << 1) ^ g : a << 1;
        return a >> (32 - w);
    endfunction

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic setup(input scu_poly_type p);
        @(negedge clk);
        clear_strobe = 1;
        config_write = 1;
        config_poly = p;
        @(negedge clk);
        clear_strobe = 0;
        config_write = 0;
    endtask

    // request held until an edge with snoop_ready high takes it
    task automatic beat(input scu_row_type r, input logic c, input logic s);
        cur = r;
        cd_go = c;
        sb_go = s;
        while (!bus_if.snoop_ready) @(negedge clk);
        @(negedge clk);
    endtask

    task automatic settle();
        cd_go = 0;
        sb_go = 0;
        for (int k = 0; k < 100 && (busy_reg || bus_if.cd_valid || bus_if.sb_valid); k++)
            @(negedge clk);
        chk("settle", 32'h0, {29'h0, busy_reg, bus_if.cd_valid, bus_if.sb_valid});
        repeat (3) @(negedge clk);
    endtask

    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    // whole run is well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        {cd_go, sb_go, clear_strobe, config_write, result_write} = '0;
        config_poly = SCU_POLY_8;
        result_wdata = '0;
        cur = rows[0];
        error_cnt = 0;
        check_count = 0;
        sys_rst = 1;
        repeat (5) @(negedge clk);
        sys_rst = 0;
        foreach (rows[i]) begin
            setup(rows[i].poly);
            beat(rows[i], !rows[i].sb, rows[i].sb);
            settle();
            e = crc(RESULT_RESET, rows[i].sb ? ~rows[i].dat : rows[i].dat, rows[i].poly);
            chk("result", rows[i].fold ? e : RESULT_RESET, crc_result_reg);
            chk("config", {30'h0, rows[i].poly}, {30'h0, crc_config_reg});
            if (!rows[i].sb && rows[i].fl[4:2] == 3'h0)
                chk("rdata", |rows[i].fl[1:0] ? 32'h0 : {24'h5a5a5a, rows[i].dat},
                    cd_rdata_reg);
            $display("row %0d done", i);
        end
        // both buses in one cycle: code byte folds first
        setup(SCU_POLY_16_SECOND);
        beat(rows[0], 1, 1);
        settle();
        chk("both", crc(crc(0, 8'ha5, SCU_POLY_16_SECOND), 8'h5a, SCU_POLY_16_SECOND),
            crc_result_reg);
        $display("dual bus done");
        // restore held while bytes pile up: fifo fills, refuses, then drains
        setup(SCU_POLY_32);
        result_wdata = 32'h1234_5678;
        result_write = 1;
        fork
            begin
                repeat (10) @(negedge clk);
                chk("ready_stall", 32'h0, {31'h0, req_ready_reg});
                chk("busy_stall", 32'h1, {31'h0, busy_reg});
                result_write = 0;
            end
        join_none
        e = 32'h1234_5678;
        for (int j = 1; j <= 8; j++) begin
            cur.dat = 8'(j);
            beat(cur, 1, 0);
            e = crc(e, 8'(j), SCU_POLY_32);
        end
        settle();
        chk("resume", e, crc_result_reg);
        chk("ready", 32'h1, {31'h0, req_ready_reg});
        @(negedge clk);
        clear_strobe = 1;
        result_write = 1;
        @(negedge clk);
        clear_strobe = 0;
        result_write = 0;
        chk("clear_wins", RESULT_RESET, crc_result_reg);
        $display("fifo and restore done");
        // reset in mid-run
        setup(SCU_POLY_32);
        result_write = 1;
        @(negedge clk);
        result_write = 0;
        sys_rst = 1;
        repeat (2) @(negedge clk);
        sys_rst = 0;
        chk("rst_result", RESULT_RESET, crc_result_reg);
        chk("rst_config", {30'h0, SCU_POLY_8}, {30'h0, crc_config_reg});
        chk("rst_ready", 32'h0, {31'h0, req_ready_reg});
        chk("rst_busy", 32'h0, {31'h0, busy_reg});
        $display("reset done");
        tally_and_finish();
    end
endmodule
